// File: ocd_osc_control.sv
// Operation
// - PLL-settled reads 1 when PLL locked or start-up timer expired, else 0.
// - PLL-settled forced 0 during a valid switch and in non-PLL modes.
// - Clock-fail flag sets when the fail-safe monitor reports a clock failure while switching is permitted.
// - Secondary oscillator runs while its enable bit is 1.
// - Writing 1 to switch request starts a switch to the new-source field.
// - Switch request reads 0 once the switch has completed.
// - Reset loads current and new source fields from the boot source setting.
// - Unimplemented bits read 0 and ignore writes.
// - CPU ratio code n gives CPU to peripheral ratio 1:2^n.
// - CPU ratio applies only while ratio-apply enable is 1, else 1:1.
// - Fast RC postscaler divides by 2^code; 110 gives 125 kHz, 101 gives 250 kHz.
// - An interrupt with wake-restore set clears ratio-apply enable.
// - Request with new source equal to current source is aborted and cleared.
// - A valid switch start clears PLL-settled and clock-fail flags.
// - Switching disabled holds switch request at 0; the new-source field still takes writes.
`timescale 1ns/100ps
module ocd_osc_control (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [2:0] boot_source_config_in,
    input wire logic switch_permit_config_n_in,
    input wire logic pll_locked_in,
    input wire logic osc_startup_timer_done_in,
    input wire logic fail_safe_monitor_fail_in,
    input wire logic mux_switched_in,
    input wire logic fast_rc_osc_in,
    input wire logic cpu_irq_in,
    output logic switch_start_out,
    output logic [2:0] switch_target_out,
    output logic [2:0] current_source_out,
    output logic pll_settled_out,
    output logic clock_fail_flag_out,
    output logic secondary_osc_enable_out,
    output logic cpu_clk_en_out,
    output logic fast_rc_clk_en_out,
    output logic irq_out
);
    import ocd_pkg::*;

    typedef struct packed {
        ocd_state_e st;
        logic [1:0] boot_cnt;
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic frc_prev;
        logic [2:0] current_source_status;
        logic [2:0] new_source_select;
        logic switch_request;
        logic cf;
        logic secondary_osc;
        logic start;
        logic wake_restore_ratio;
        logic [2:0] cpu_ratio_select;
        logic ratio_apply_enable;
        logic [2:0] fast_rc_postdiv;
        logic [INT_W-1:0] int_status;
        logic [INT_W-1:0] int_mask;
        logic [31:0] prdata;
    } ocd_regs_s;

    ocd_regs_s r;
    ocd_regs_s next_r;

    logic wr_access;
    logic rd_setup;
    logic mapped;
    logic permit;
    logic pll_mode;
    logic pll_settled;
    logic [2:0] ratio_code;
    logic frc_edge;
    logic [15:0] osc_word;
    logic [15:0] div_word;
    logic [INT_W-1:0] events;
    logic [2:0] req_new_source_select;

    assign mapped = (paddr_in == OCD_ADDR_OSC_CONTROL) || (paddr_in == OCD_ADDR_CLOCK_DIVIDER) ||
        (paddr_in == OCD_ADDR_INT_STATUS) || (paddr_in == OCD_ADDR_INT_MASK);
    assign pready_out = psel_in && penable_in;
    assign pslverr_out = pready_out && !mapped;
    assign wr_access = pready_out && pwrite_in && mapped;
    assign rd_setup = psel_in && !penable_in;

    assign permit = !r.sync2[SY_PERMIT_N];
    assign pll_mode = (r.current_source_status == SRC_FRC_PLL) || (r.current_source_status == SRC_PRI_PLL);
    // Settled only outside a switch and in a PLL mode
    assign pll_settled = (r.st == ST_IDLE) && pll_mode &&
        (r.sync2[SY_PLL_LOCK] || r.sync2[SY_PLL_TIMER]);
    assign frc_edge = r.sync2[SY_FRC] && !r.frc_prev;
    // Ratio falls back to 1:1 while apply enable is low
    assign ratio_code = r.ratio_apply_enable ? r.cpu_ratio_select : 3'h0;

    // Unimplemented bits read as zero
    assign osc_word = {1'b0, r.current_source_status, 1'b0, r.new_source_select, 2'b00, pll_settled, 1'b0, r.cf,
        1'b0, r.secondary_osc, r.switch_request};
    assign div_word = {r.wake_restore_ratio, r.cpu_ratio_select, r.ratio_apply_enable, r.fast_rc_postdiv, 8'h00};

    always_comb begin
        next_r = r;
        events = '0;
        req_new_source_select = r.new_source_select;
        next_r.sync1 = {fast_rc_osc_in, mux_switched_in, fail_safe_monitor_fail_in,
            osc_startup_timer_done_in, pll_locked_in, switch_permit_config_n_in,
            boot_source_config_in};
        next_r.sync2 = r.sync1;
        next_r.frc_prev = r.sync2[SY_FRC];
        next_r.start = 1'b0;

        if (rd_setup) begin
            case (paddr_in)
                OCD_ADDR_OSC_CONTROL: next_r.prdata = {16'h0000, osc_word};
                OCD_ADDR_CLOCK_DIVIDER: next_r.prdata = {16'h0000, div_word};
                OCD_ADDR_INT_STATUS: next_r.prdata = {{(32 - INT_W){1'b0}}, r.int_status};
                OCD_ADDR_INT_MASK: next_r.prdata = {{(32 - INT_W){1'b0}}, r.int_mask};
                default: next_r.prdata = 32'h0000_0000;
            endcase
        end

        if (wr_access) begin
            case (paddr_in)
                OCD_ADDR_OSC_CONTROL: begin
                    next_r.secondary_osc = pwdata_in[OSC_SECONDARY_OSC_EN_BIT];
                    if (!pwdata_in[OSC_CLOCK_FAIL_BIT]) begin
                        next_r.cf = 1'b0;
                    end
                    if (r.st != ST_SWITCH) begin
                        req_new_source_select = pwdata_in[OSC_NEW_SOURCE_SELECT_LSB +: 3];
                        next_r.new_source_select = req_new_source_select;
                    end
                end
                OCD_ADDR_CLOCK_DIVIDER: begin
                    next_r.wake_restore_ratio = pwdata_in[DIV_WAKE_RESTORE_BIT];
                    next_r.cpu_ratio_select = pwdata_in[DIV_CPU_RATIO_LSB +: 3];
                    next_r.ratio_apply_enable = pwdata_in[DIV_RATIO_APPLY_BIT];
                    next_r.fast_rc_postdiv = pwdata_in[DIV_FRC_POSTDIV_LSB +: 3];
                end
                OCD_ADDR_INT_MASK: next_r.int_mask = pwdata_in[INT_W-1:0];
                default: begin
                end
            endcase
        end

        // Interrupt clears ratio apply when wake restore is set
        if (cpu_irq_in && r.wake_restore_ratio) begin
            next_r.ratio_apply_enable = 1'b0;
        end

        case (r.st)
            ST_BOOT: begin
                next_r.boot_cnt = r.boot_cnt + 2'h1;
                if (r.boot_cnt == BOOT_SYNC_CYCLES) begin
                    // Both source fields follow the boot setting
                    next_r.current_source_status = r.sync2[SY_BOOT_LSB +: 3];
                    next_r.new_source_select = r.sync2[SY_BOOT_LSB +: 3];
                    next_r.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (wr_access && (paddr_in == OCD_ADDR_OSC_CONTROL) &&
                    pwdata_in[OSC_SWITCH_REQ_BIT] && permit) begin
                    if (req_new_source_select == r.current_source_status) begin
                        events[INT_SWITCH_ABORT] = 1'b1;
                    end else begin
                        next_r.switch_request = 1'b1;
                        next_r.start = 1'b1;
                        next_r.cf = 1'b0;
                        next_r.st = ST_SWITCH;
                    end
                end
            end
            ST_SWITCH: begin
                // Request held until the multiplexer has moved or switching is disabled
                if (r.sync2[SY_MUX_DONE]) begin
                    next_r.switch_request = 1'b0;
                    next_r.current_source_status = r.new_source_select;
                    next_r.st = ST_IDLE;
                    events[INT_SWITCH_DONE] = 1'b1;
                end
            end
            default: next_r.st = ST_BOOT;
        endcase

        if (!permit) begin
            next_r.switch_request = 1'b0;
        end

        // Monitor reports only while switching is permitted; set wins over a write clear, a switch start wins over set
        if (permit && r.sync2[SY_FAIL] && !next_r.start) begin
            next_r.cf = 1'b1;
            events[INT_CLOCK_FAIL] = !r.cf;
        end

        next_r.int_status = r.int_status;
        if (wr_access && (paddr_in == OCD_ADDR_INT_STATUS)) begin
            next_r.int_status = r.int_status & ~pwdata_in[INT_W-1:0];
        end
        next_r.int_status = next_r.int_status | events;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '0;
            r.st <= ST_BOOT;
            r.wake_restore_ratio <= DIV_WAKE_RESTORE_RST;
            r.cpu_ratio_select <= DIV_CPU_RATIO_RST;
            r.ratio_apply_enable <= DIV_RATIO_APPLY_RST;
            r.fast_rc_postdiv <= DIV_FRC_POSTDIV_RST;
        end else if (clk_en_in) begin
            r <= next_r;
        end
    end

    // CPU clock enable, one pulse per 2^n system cycles
    ocd_pow2_tick #(
        .CODE_W(3)
    ) u_cpu_ratio (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .step_in(1'b1),
        .code_in(ratio_code),
        .tick_out(cpu_clk_en_out)
    );

    // Fast RC postscaler, one pulse per 2^code oscillator rising edges
    ocd_pow2_tick #(
        .CODE_W(3)
    ) u_frc_postdiv (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .step_in(frc_edge),
        .code_in(r.fast_rc_postdiv),
        .tick_out(fast_rc_clk_en_out)
    );

    assign prdata_out = r.prdata;
    assign switch_start_out = r.start;
    assign switch_target_out = r.new_source_select;
    assign current_source_out = r.current_source_status;
    assign pll_settled_out = pll_settled;
    assign clock_fail_flag_out = r.cf;
    assign secondary_osc_enable_out = r.secondary_osc;
    assign irq_out = |(r.int_status & r.int_mask);

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_switch_write;
        clk_en_in && r.st == ST_IDLE && wr_access && paddr_in == OCD_ADDR_OSC_CONTROL &&
            pwdata_in[OSC_SWITCH_REQ_BIT] && permit;
    endsequence

    sequence s_valid_switch;
        s_switch_write ##0 (pwdata_in[OSC_NEW_SOURCE_SELECT_LSB +: 3] != r.current_source_status);
    endsequence

    property p_pll_locked;
        (r.st == ST_IDLE && pll_mode && r.sync2[SY_PLL_LOCK]) |-> pll_settled_out;
    endproperty
    a_pll_locked: assert property (p_pll_locked) else $error("PLL settled not shown");

    property p_pll_in_switch;
        s_valid_switch |=> (!pll_settled_out && !clock_fail_flag_out);
    endproperty
    a_pll_in_switch: assert property (p_pll_in_switch) else $error("Flags not cleared");

    property p_fail_sets;
        (clk_en_in && permit && r.sync2[SY_FAIL] && !next_r.start) |=> clock_fail_flag_out;
    endproperty
    a_fail_sets: assert property (p_fail_sets) else $error("Clock fail not flagged");

    property p_secondary_osc_write;
        (clk_en_in && wr_access && paddr_in == OCD_ADDR_OSC_CONTROL)
            |=> secondary_osc_enable_out == $past(pwdata_in[OSC_SECONDARY_OSC_EN_BIT]);
    endproperty
    a_secondary_osc_write: assert property (p_secondary_osc_write) else $error("Oscillator enable wrong");

    property p_switch_starts;
        s_valid_switch |=> (switch_start_out && r.switch_request) ##1 !switch_start_out;
    endproperty
    a_switch_starts: assert property (p_switch_starts) else $error("Switch not started");

    property p_switch_done;
        (clk_en_in && r.st == ST_SWITCH && r.sync2[SY_MUX_DONE])
            |=> (!r.switch_request && current_source_out == $past(r.new_source_select));
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("Switch not completed");

    property p_switch_held;
        (r.st == ST_SWITCH && !r.sync2[SY_MUX_DONE] && permit) |=> r.switch_request;
    endproperty
    a_switch_held: assert property (p_switch_held) else $error("Request dropped early");

    property p_redundant;
        (s_switch_write ##0 (pwdata_in[OSC_NEW_SOURCE_SELECT_LSB +: 3] == r.current_source_status))
            |=> (!r.switch_request && r.int_status[INT_SWITCH_ABORT]);
    endproperty
    a_redundant: assert property (p_redundant) else $error("Redundant switch ran");

    property p_disabled;
        (clk_en_in && !permit) |=> !r.switch_request;
    endproperty
    a_disabled: assert property (p_disabled) else $error("Request set while disabled");

    property p_restore;
        (clk_en_in && cpu_irq_in && r.wake_restore_ratio) |=> !r.ratio_apply_enable;
    endproperty
    a_restore: assert property (p_restore) else $error("Ratio apply not cleared");

    property p_ratio_off;
        (clk_en_in && !r.ratio_apply_enable) [*2] |=> cpu_clk_en_out;
    endproperty
    a_ratio_off: assert property (p_ratio_off) else $error("CPU ratio not 1:1");

    property p_reserved_read;
        (pready_out && !pwrite_in && paddr_in == OCD_ADDR_CLOCK_DIVIDER)
            |-> prdata_out[7:0] == 8'h00 && prdata_out[31:16] == 16'h0000;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("Reserved bits set");

endmodule : ocd_osc_control

// File: ocd_pkg.sv
package ocd_pkg;

    // Register byte addresses
    localparam logic [7:0] OCD_ADDR_OSC_CONTROL = 8'h00;
    localparam logic [7:0] OCD_ADDR_CLOCK_DIVIDER = 8'h04;
    localparam logic [7:0] OCD_ADDR_INT_STATUS = 8'h08;
    localparam logic [7:0] OCD_ADDR_INT_MASK = 8'h0C;

    // Oscillator control field positions
    localparam int OSC_CURRENT_SOURCE_STATUS_LSB = 12;
    localparam int OSC_NEW_SOURCE_SELECT_LSB = 8;
    localparam int OSC_PLL_SETTLED_BIT = 5;
    localparam int OSC_CLOCK_FAIL_BIT = 3;
    localparam int OSC_SECONDARY_OSC_EN_BIT = 1;
    localparam int OSC_SWITCH_REQ_BIT = 0;

    // Clock divider field positions
    localparam int DIV_WAKE_RESTORE_BIT = 15;
    localparam int DIV_CPU_RATIO_LSB = 12;
    localparam int DIV_RATIO_APPLY_BIT = 11;
    localparam int DIV_FRC_POSTDIV_LSB = 8;

    // Clock divider reset values
    localparam logic DIV_WAKE_RESTORE_RST = 1'b0;
    localparam logic [2:0] DIV_CPU_RATIO_RST = 3'h0;
    localparam logic DIV_RATIO_APPLY_RST = 1'b0;
    localparam logic [2:0] DIV_FRC_POSTDIV_RST = 3'h1;

    // Clock sources that run through the PLL
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;

    // Interrupt status bits
    localparam int INT_W = 3;
    localparam int INT_CLOCK_FAIL = 0;
    localparam int INT_SWITCH_DONE = 1;
    localparam int INT_SWITCH_ABORT = 2;

    // Synchroniser vector layout
    localparam int SYNC_W = 9;
    localparam int SY_BOOT_LSB = 0;
    localparam int SY_PERMIT_N = 3;
    localparam int SY_PLL_LOCK = 4;
    localparam int SY_PLL_TIMER = 5;
    localparam int SY_FAIL = 6;
    localparam int SY_MUX_DONE = 7;
    localparam int SY_FRC = 8;

    // Cycles after reset release before the boot setting is trusted
    localparam logic [1:0] BOOT_SYNC_CYCLES = 2'h2;

    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_IDLE = 2'b01,
        ST_SWITCH = 2'b10
    } ocd_state_e;

endpackage : ocd_pkg

// File: ocd_pow2_tick.sv
`timescale 1ns/100ps
module ocd_pow2_tick #(
    parameter int CODE_W = 3
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic step_in,
    input wire logic [CODE_W-1:0] code_in,
    output logic tick_out
);
    localparam int CNT_W = (1 << CODE_W) - 1;

    generate
        if (CODE_W < 1 || CODE_W > 5) begin : g_bad_width
            $error("ocd_pow2_tick: CODE_W must be 1 to 5");
        end
    endgenerate

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic tick;
    } ocd_tick_s;

    ocd_tick_s r;
    ocd_tick_s next_r;
    logic [CNT_W-1:0] last_count;

    // One tick per 2^code steps
    always_comb begin
        next_r = r;
        last_count = CNT_W'((64'h1 << code_in) - 64'h1);
        next_r.tick = 1'b0;
        if (step_in) begin
            if (r.count >= last_count) begin
                next_r.count = '0;
                next_r.tick = 1'b1;
            end else begin
                next_r.count = r.count + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            r <= '0;
        end else if (clk_en_in) begin
            r <= next_r;
        end
    end

    assign tick_out = r.tick;

endmodule : ocd_pow2_tick

// File: osc_control_and_clock_divider_tb_top.sv
`timescale 1ns/100ps
module osc_control_and_clock_divider_tb_top;
    import ocd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] boot_cfg = 3'h2;
    logic permit_n = 1'b0;
    logic pll_lock = 1'b1;
    logic ost_done = 1'b0;
    logic mon_fail = 1'b0;
    logic mux_done = 1'b0;
    logic fast_rc_osc = 1'b0;
    logic irq_in = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sw_start;
    logic [2:0] sw_tgt;
    logic [2:0] cur_src;
    logic pll_settled;
    logic cf_flag;
    logic secondary_osc_en;
    logic cpu_en;
    logic frc_en;
    logic irq;
    int mismatches = 0;
    int checked = 0;

    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        fast_rc_osc <= ~fast_rc_osc;
    end

    ocd_osc_control ocd_osc_control_i (
        .clk_sys_in(clk_sys), .rst_n_in(rst_n), .clk_en_in(clk_en), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .boot_source_config_in(boot_cfg), .switch_permit_config_n_in(permit_n),
        .pll_locked_in(pll_lock), .osc_startup_timer_done_in(ost_done),
        .fail_safe_monitor_fail_in(mon_fail), .mux_switched_in(mux_done),
        .fast_rc_osc_in(fast_rc_osc), .cpu_irq_in(irq_in), .switch_start_out(sw_start),
        .switch_target_out(sw_tgt), .current_source_out(cur_src), .pll_settled_out(pll_settled),
        .clock_fail_flag_out(cf_flag), .secondary_osc_enable_out(secondary_osc_en),
        .cpu_clk_en_out(cpu_en), .fast_rc_clk_en_out(frc_en), .irq_out(irq)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_cnt

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, exp);
    endtask : rd

    task automatic peek(input int n, ref logic got, input logic exp);
        repeat (n) @(negedge clk_sys);
        chk({31'h0, got}, {31'h0, exp});
    endtask : peek

    task automatic watch_start(input int n, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge clk_sys);
            if (sw_start === 1'b1) seen = 1'b1;
        end
        chk({31'h0, seen}, {31'h0, exp});
    endtask : watch_start

    task automatic count(input int n, input logic sel, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if ((sel ? frc_en : cpu_en) === 1'b1) c++;
        end
    endtask : count

    task automatic t_reset;
        rd(OCD_ADDR_CLOCK_DIVIDER, 32'hFFFF_FFFF, 32'h0000_0100);
        rd(OCD_ADDR_OSC_CONTROL, 32'hFFFF_FFFF, 32'h0000_2200);
        peek(1, pll_settled, 1'b0);
    endtask : t_reset

    task automatic t_regs;
        logic [31:0] r;
        logic e;
        wr(OCD_ADDR_OSC_CONTROL, 32'h0000_0216);
        rd(OCD_ADDR_OSC_CONTROL, 32'hFFFF_FFFF, 32'h0000_2202);
        peek(2, secondary_osc_en, 1'b1);
        wr(OCD_ADDR_OSC_CONTROL, 32'h0000_0200);
        peek(2, secondary_osc_en, 1'b0);
        wr(OCD_ADDR_CLOCK_DIVIDER, 32'hFFFF_FFFF);
        rd(OCD_ADDR_CLOCK_DIVIDER, 32'hFFFF_FFFF, 32'h0000_FF00);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
    endtask : t_regs

    task automatic t_redundant;
        wr(OCD_ADDR_OSC_CONTROL, 32'h0000_0201);
        watch_start(6, 1'b0);
        rd(OCD_ADDR_OSC_CONTROL, 32'h0000_7001, 32'h0000_2000);
        rd(OCD_ADDR_INT_STATUS, 32'h0000_0004, 32'h0000_0004);
        wr(OCD_ADDR_INT_MASK, 32'h0000_0005);
        peek(1, irq, 1'b1);
        wr(OCD_ADDR_INT_STATUS, 32'h0000_0004);
        peek(1, irq, 1'b0);
    endtask : t_redundant

    task automatic t_switch;
        logic [31:0] d;
        logic e;
        int n;
        @(posedge clk_sys);
        mon_fail <= 1'b1;
        peek(6, cf_flag, 1'b1);
        peek(0, irq, 1'b1);
        rd(OCD_ADDR_OSC_CONTROL, 32'h0000_0008, 32'h0000_0008);
        mon_fail <= 1'b0;
        wr(OCD_ADDR_OSC_CONTROL, 32'h0000_0301);
        watch_start(4, 1'b1);
        chk({29'h0, sw_tgt}, 32'h3);
        peek(0, cf_flag, 1'b0);
        peek(10, pll_settled, 1'b0);
        rd(OCD_ADDR_OSC_CONTROL, 32'h0000_7001, 32'h0000_2001);
        mux_done <= 1'b1;
        n = 0;
        do begin
            apb(1'b0, OCD_ADDR_OSC_CONTROL, 32'h0, d, e);
            n++;
        end while (d[0] !== 1'b0 && n < 20);
        chk(d & 32'h0000_7001, 32'h0000_3000);
        chk({29'h0, cur_src}, 32'h3);
        peek(4, pll_settled, 1'b1);
        @(posedge clk_sys);
        pll_lock <= 1'b0;
        peek(6, pll_settled, 1'b0);
        @(posedge clk_sys);
        ost_done <= 1'b1;
        peek(6, pll_settled, 1'b1);
        @(posedge clk_sys);
        mux_done <= 1'b0;
        permit_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        wr(OCD_ADDR_OSC_CONTROL, 32'h0000_0201);
        watch_start(6, 1'b0);
        rd(OCD_ADDR_OSC_CONTROL, 32'h0000_7001, 32'h0000_3000);
        permit_n <= 1'b0;
    endtask : t_switch

    task automatic t_ratio;
        int c;
        wr(OCD_ADDR_CLOCK_DIVIDER, 32'h0000_3100);
        repeat (2) @(negedge clk_sys);
        count(16, 1'b0, c);
        chk_cnt(c, 16);
        for (int k = 0; k < 8; k++) begin
            wr(OCD_ADDR_CLOCK_DIVIDER, 32'h0000_0900 | (k << 12));
            repeat (300) @(negedge clk_sys);
            count(256, 1'b0, c);
            chk_cnt(c, 256 >> k);
        end
        wr(OCD_ADDR_CLOCK_DIVIDER, 32'h0000_A900);
        irq_in <= 1'b1;
        @(posedge clk_sys);
        irq_in <= 1'b0;
        rd(OCD_ADDR_CLOCK_DIVIDER, 32'hFFFF_FFFF, 32'h0000_A100);
    endtask : t_ratio

    task automatic t_frc;
        int c;
        for (int k = 0; k < 8; k++) begin
            wr(OCD_ADDR_CLOCK_DIVIDER, k << 8);
            repeat (600) @(negedge clk_sys);
            count(1024, 1'b1, c);
            chk_cnt(c, 512 >> k);
        end
    endtask : t_frc

    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk_sys);
        t_reset();
        t_regs();
        t_redundant();
        t_switch();
        t_ratio();
        t_frc();
        end_sim();
    end

    initial begin
        #(40 * 40000);
        mismatches++;
        end_sim();
    end
endmodule : osc_control_and_clock_divider_tb_top
